/* File: core/iwb_port.sv */
// external data move engine with 8/16-bit bus and the high data byte register
// assumes the cpu issues one move at a time and holds auxiliary control bits steady
`timescale 1ns/1ns
`include "iwb_params.svh"
// Notes on behaviour
// - with wide mode set, every external move is a 16-bit transfer, else 8-bit
// - low port carries low address then low data byte
// - high port carries high address then high data byte in wide mode
// - wide write: low byte from move request data, high byte from holding register
// - wide read: low byte to cpu result, high byte captured into holding register
// - a bus cycle lasts six cpu clock periods, eighteen with the stretch bit set
// - stretch bit widens read and write strobes from 3 to 15 cpu periods
// - index-register moves put the high port register on the high port
// - pointer moves with page access disable put the high port register out
// - address latch strobe marks a valid address on the low lines
module iwb_port
   import iwb_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset,
   // clocking and auxiliary control bits
   input  wire logic       double_speed,
   input  wire logic       wide_bus_enable,
   input  wire logic       strobe_stretch,
   input  wire logic       page_access_disable,
   input  wire logic [7:0] high_port_reg,
   // special function register access
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // external move request from the cpu
   input  wire iwb_req_t   move_req,
   input  wire logic       move_valid,
   output logic            move_busy,
   output logic            move_done,
   output logic      [7:0] cpu_result,
   // pins
   output iwb_pins_t       pins,
   input  wire logic [7:0] low_port_in,
   input  wire logic [7:0] high_port_in
);
   iwb_state_t state_r, state_nxt;
   iwb_req_t   req_r, req_nxt;
   iwb_pins_t  pins_r, pins_nxt;
   logic       wide_r, wide_nxt, stretch_r, stretch_nxt, pgdis_r, pgdis_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic       div_r, div_nxt, tick;
   logic [7:0] hi_byte_r, hi_byte_nxt, result_r, result_nxt, rdata_r, rdata_nxt;
   logic       busy_r, busy_nxt, done_r, done_nxt;
   logic [7:0] lo_s1_r, lo_s2_r, hi_s1_r, hi_s2_r;
   logic [7:0] hi_addr;
   logic       last_tick;

   function automatic logic [3:0] phase_len(input iwb_state_t st, input logic stretch);
      unique case (st)
         IWB_ADDR:   phase_len = `IWB_ADDR_TICKS;
         IWB_HOLD:   phase_len = `IWB_HOLD_TICKS;
         IWB_STROBE: phase_len = stretch ? `IWB_STRETCH_TICKS : `IWB_STROBE_TICKS;
         IWB_RECOV:  phase_len = `IWB_RECOV_TICKS;
         default:    phase_len = `IWB_ADDR_TICKS;
      endcase
   endfunction

   // cpu clock enable: every oscillator cycle in double speed, else every second one
   assign tick = double_speed | (div_r == `IWB_OSC_PER_CPU_STD);
   assign last_tick = tick && (cnt_r == phase_len(state_r, stretch_r) - 4'h1);
   // high address source: port register for index moves or disabled page access
   assign hi_addr = (req_r.via_index || pgdis_r) ? high_port_reg : req_r.addr[15:8];

   always_comb
   begin
      state_nxt   = state_r;
      req_nxt     = req_r;
      wide_nxt    = wide_r;
      stretch_nxt = stretch_r;
      pgdis_nxt   = pgdis_r;
      cnt_nxt     = cnt_r;
      div_nxt     = ~div_r;
      hi_byte_nxt = hi_byte_r;
      result_nxt  = result_r;
      busy_nxt    = busy_r;
      done_nxt    = 1'b0;
      rdata_nxt   = (sfr_addr == `IWB_SFR_WIDE_HI) ? hi_byte_r : `IWB_SFR_READ_ZERO;
      if (sfr_wr && sfr_addr == `IWB_SFR_WIDE_HI)
         hi_byte_nxt = sfr_wdata;
      if (state_r == IWB_IDLE)
      begin
         if (move_valid)
         begin
            req_nxt     = move_req;
            wide_nxt    = wide_bus_enable;
            stretch_nxt = strobe_stretch;
            pgdis_nxt   = page_access_disable & ~move_req.via_index;
            state_nxt   = IWB_ADDR;
            cnt_nxt     = 4'h0;
            div_nxt     = 1'b0;
            busy_nxt    = 1'b1;
         end
      end
      else if (last_tick)
      begin
         cnt_nxt = 4'h0;
         unique case (state_r)
            IWB_ADDR:   state_nxt = IWB_HOLD;
            IWB_HOLD:   state_nxt = IWB_STROBE;
            IWB_STROBE:
            begin
               state_nxt = IWB_RECOV;
               if (!req_r.is_write)
               begin
                  result_nxt = lo_s2_r;
                  if (wide_r)
                     hi_byte_nxt = hi_s2_r;
               end
            end
            default:
            begin
               state_nxt = IWB_IDLE;
               busy_nxt  = 1'b0;
               done_nxt  = 1'b1;
            end
         endcase
      end
      else if (tick)
         cnt_nxt = cnt_r + 4'h1;
   end

   // pin values follow the next state so that they leave flip-flops aligned with it
   always_comb
   begin
      pins_nxt        = '0;
      pins_nxt.rd_n   = 1'b1;
      pins_nxt.wr_n   = 1'b1;
      pins_nxt.hi_out = (state_r == IWB_IDLE) ? move_req.addr[15:8] : hi_addr;
      if (state_r == IWB_IDLE)
      begin
         if (move_req.via_index || page_access_disable)
            pins_nxt.hi_out = high_port_reg;
      end
      unique case (state_nxt)
         IWB_ADDR:
         begin
            pins_nxt.ale    = 1'b1;
            pins_nxt.lo_out = req_nxt.addr[7:0];
            pins_nxt.lo_oe  = 1'b1;
            pins_nxt.hi_oe  = 1'b1;
         end
         IWB_HOLD:
         begin
            pins_nxt.lo_out = req_r.addr[7:0];
            pins_nxt.lo_oe  = 1'b1;
            pins_nxt.hi_oe  = 1'b1;
         end
         IWB_STROBE, IWB_RECOV:
         begin
            pins_nxt.rd_n = !(state_nxt == IWB_STROBE && !req_r.is_write);
            pins_nxt.wr_n = !(state_nxt == IWB_STROBE && req_r.is_write);
            pins_nxt.lo_out = req_r.data;
            pins_nxt.lo_oe  = req_r.is_write;
            pins_nxt.hi_oe  = req_r.is_write || !wide_r;
            if (wide_r && req_r.is_write)
               pins_nxt.hi_out = hi_byte_r;
         end
         default:
            pins_nxt.hi_out = '0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      lo_s1_r <= low_port_in;
      lo_s2_r <= lo_s1_r;
      hi_s1_r <= high_port_in;
      hi_s2_r <= hi_s1_r;
      if (reset)
      begin
         state_r   <= IWB_IDLE;
         req_r     <= '0;
         wide_r    <= 1'b0;
         stretch_r <= 1'b0;
         pgdis_r   <= 1'b0;
         cnt_r     <= 4'h0;
         div_r     <= 1'b0;
         hi_byte_r <= `IWB_WIDE_HI_RESET;
         result_r  <= 8'h00;
         rdata_r   <= 8'h00;
         busy_r    <= 1'b0;
         done_r    <= 1'b0;
         pins_r    <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, lo_out: 8'h00, lo_oe: 1'b0,
                        hi_out: 8'h00, hi_oe: 1'b0};
      end
      else
      begin
         state_r   <= state_nxt;
         req_r     <= req_nxt;
         wide_r    <= wide_nxt;
         stretch_r <= stretch_nxt;
         pgdis_r   <= pgdis_nxt;
         cnt_r     <= cnt_nxt;
         div_r     <= div_nxt;
         hi_byte_r <= hi_byte_nxt;
         result_r  <= result_nxt;
         rdata_r   <= rdata_nxt;
         busy_r    <= busy_nxt;
         done_r    <= done_nxt;
         pins_r    <= pins_nxt;
      end
   end

   assign pins       = pins_r;
   assign move_busy  = busy_r;
   assign move_done  = done_r;
   assign cpu_result = result_r;
   assign sfr_rdata  = rdata_r;

   // helper: cpu ticks since the cycle began
   logic [4:0] ticks_r;
   always_ff @(posedge mclk)
   begin
      if (reset || state_r == IWB_IDLE)
         ticks_r <= 5'h00;
      else if (tick)
         ticks_r <= ticks_r + 5'h01;
   end

   a_cycle_length: assert property (@(posedge mclk) disable iff (reset)
      $fell(busy_r) |-> ($past(ticks_r) + 5'h01 ==
                         ($past(stretch_r) ? `IWB_CYCLE_TICKS_LONG : `IWB_CYCLE_TICKS)))
      else $error("bus cycle length wrong");
   a_ale_addr: assert property (@(posedge mclk) disable iff (reset)
      pins_r.ale |-> pins_r.lo_oe && pins_r.lo_out == req_r.addr[7:0] && pins_r.rd_n
                     && pins_r.wr_n)
      else $error("latch strobe without address");
   a_ale_first: assert property (@(posedge mclk) disable iff (reset)
      $rose(busy_r) |-> pins_r.ale)
      else $error("cycle did not open with latch strobe");
   a_strobe_excl: assert property (@(posedge mclk) disable iff (reset)
      !(pins_r.rd_n == 1'b0 && pins_r.wr_n == 1'b0) && !(!pins_r.rd_n && pins_r.lo_oe))
      else $error("strobe overlap or drive conflict");
   a_wide_write: assert property (@(posedge mclk) disable iff (reset)
      (!pins_r.wr_n && wide_r) |-> pins_r.hi_out == hi_byte_r
                                   && pins_r.lo_out == req_r.data)
      else $error("wide write data wrong");
   a_wide_read_hi: assert property (@(posedge mclk) disable iff (reset)
      (state_r == IWB_STROBE && last_tick && !req_r.is_write && wide_r)
      |=> hi_byte_r == $past(hi_s2_r) && cpu_result == $past(lo_s2_r))
      else $error("wide read capture wrong");
   a_narrow_keep: assert property (@(posedge mclk) disable iff (reset)
      (busy_r && !wide_r && !$past(sfr_wr)) |-> $stable(hi_byte_r) && pins_r.hi_oe)
      else $error("narrow move touched high byte");
   a_index_high: assert property (@(posedge mclk) disable iff (reset)
      (pins_r.ale && (req_r.via_index || pgdis_r)) |-> pins_r.hi_out == $past(high_port_reg))
      else $error("high port not from port register");
   a_read_release: assert property (@(posedge mclk) disable iff (reset)
      (!pins_r.rd_n && wide_r) |-> !pins_r.hi_oe && !pins_r.lo_oe)
      else $error("port driven during wide read");
endmodule // iwb_port

/* File: shared/iwb_params.svh */
// constants of the wide external bus port: register address, cycle phase lengths
// assumes a cpu clock period of two oscillator periods, or one in double-speed mode
`ifndef IWB_PARAMS_SVH
`define IWB_PARAMS_SVH
`define IWB_SFR_WIDE_HI      8'hf9
`define IWB_WIDE_HI_RESET    8'h00
`define IWB_SFR_READ_ZERO    8'h00
`define IWB_OSC_PER_CPU_STD  1'b1
`define IWB_ADDR_TICKS       4'h1
`define IWB_HOLD_TICKS       4'h1
`define IWB_STROBE_TICKS     4'h3
`define IWB_STRETCH_TICKS    4'hf
`define IWB_RECOV_TICKS      4'h1
`define IWB_CYCLE_TICKS      5'h06
`define IWB_CYCLE_TICKS_LONG 5'h12
`endif

/* File: shared/iwb_pkg.sv */
// types of the wide external bus port
// assumes iwb_params.svh is on the include path
package iwb_pkg;
   typedef enum logic [4:0] {
      IWB_IDLE   = 5'h01,
      IWB_ADDR   = 5'h02,
      IWB_HOLD   = 5'h04,
      IWB_STROBE = 5'h08,
      IWB_RECOV  = 5'h10
   } iwb_state_t;

   typedef struct packed {
      logic        is_write;
      logic        via_index;
      logic [15:0] addr;
      logic [7:0]  data;
   } iwb_req_t;

   typedef struct packed {
      logic       ale;
      logic       rd_n;
      logic       wr_n;
      logic [7:0] lo_out;
      logic       lo_oe;
      logic [7:0] hi_out;
      logic       hi_oe;
   } iwb_pins_t;
endpackage

/* File: tb/iwb_ide_model.sv */
// far-side model: external address latch plus a 16-bit ide device
// assumes the port pins struct; rd_word is the word the device returns on reads
`timescale 1ns/1ns
module iwb_ide_model
   import iwb_pkg::*;
(
   // clock and port pins
   input  wire logic        mclk,
   input  wire iwb_pins_t   pins,
   // device side
   input  wire logic [15:0] rd_word,
   output logic      [15:0] wr_word,
   output logic      [7:0]  lat_addr,
   // resolved pin levels
   output logic      [7:0]  low_port_in,
   output logic      [7:0]  high_port_in
);
   logic [15:0] last_r = 16'h0000;
   logic        dev_oe;

   assign dev_oe = !pins.rd_n;
   // released lines show the inverse of the last level, so stale data never looks valid
   always_comb
   begin
      low_port_in  = pins.lo_oe ? pins.lo_out : (dev_oe ? rd_word[7:0] : ~last_r[7:0]);
      high_port_in = pins.hi_oe ? pins.hi_out : (dev_oe ? rd_word[15:8] : ~last_r[15:8]);
   end

   always_ff @(posedge mclk)
   begin
      last_r <= {high_port_in, low_port_in};
      if (pins.ale)
         lat_addr <= pins.lo_out;
      if (!pins.wr_n)
         wr_word <= {pins.hi_out, pins.lo_out};
   end
endmodule // iwb_ide_model

/* File: tb/tb_iwb_port.sv */
// self-checking bench for the wide external bus port
// assumes iwb_params.svh on the include path and the ide model beside it
`timescale 1ns/1ns
`include "iwb_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_iwb_port
   import iwb_pkg::*;
;
   logic        mclk, reset, double_speed, wide_bus_enable, strobe_stretch;
   logic        page_access_disable, sfr_wr, move_valid, move_busy, move_done;
   logic [7:0]  high_port_reg, sfr_addr, sfr_wdata, sfr_rdata, cpu_result;
   logic [7:0]  low_port_in, high_port_in, lat_addr, hi_seen;
   logic [15:0] rd_word, wr_word;
   iwb_req_t    move_req;
   iwb_pins_t   pins;
   int          mismatches, checked, cyc, strobe_len, mpt, tk, sl;

   iwb_port iwb_port_inst (.mclk, .reset, .double_speed, .wide_bus_enable, .strobe_stretch,
      .page_access_disable, .high_port_reg, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
      .move_req, .move_valid, .move_busy, .move_done, .cpu_result, .pins, .low_port_in,
      .high_port_in);
   iwb_ide_model iwb_ide_model_inst (.mclk, .pins, .rd_word, .wr_word, .lat_addr,
      .low_port_in, .high_port_in);

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic give_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge mclk);
      #1 sfr_wr = 1'b0;
      // one idle edge so that a following write never re-raises the strobe in this step
      @(posedge mclk);
      #1;
   endtask

   task automatic sfr_get(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      @(posedge mclk);
      #1 `CHK(sfr_rdata, e)
   endtask

   // one move; records high port during address phase, strobe width and length
   task automatic mv(input logic w, input logic idx, input logic [15:0] a, input logic [7:0] d);
      move_req = {w, idx, a, d};
      move_valid = 1'b1;
      hi_seen = 8'h00;
      @(posedge mclk);
      #1 move_valid = 1'b0;
      `CHK(move_busy, 1'b1)
      cyc = 1;
      strobe_len = 0;
      while (move_done !== 1'b1 && cyc < 100)
      begin
         if (pins.ale === 1'b1) hi_seen = pins.hi_out;
         if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0) strobe_len++;
         @(posedge mclk);
         #1 cyc++;
      end
      `CHK(move_done, 1'b1)
      `CHK(move_busy, 1'b0)
   endtask

   initial
   begin
      #200000;
      mismatches++;
      give_verdict;
   end

   initial
   begin
      reset = 1'b1;
      double_speed = 1'b1;
      wide_bus_enable = 1'b1;
      strobe_stretch = 1'b0;
      page_access_disable = 1'b0;
      high_port_reg = 8'h5a;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      move_req = '0;
      move_valid = 1'b0;
      rd_word = 16'hbeef;
      repeat (12) @(posedge mclk);
      #1 reset = 1'b0;
      `CHK({pins.ale, pins.rd_n, pins.wr_n, pins.lo_oe, pins.hi_oe}, 5'b01100)
      `CHK(cpu_result, 8'h00)
      `CHK({move_busy, move_done}, 2'b00)
      // first request only after the first edge that sees reset low
      @(posedge mclk);
      #1 sfr_get(`IWB_SFR_WIDE_HI, `IWB_WIDE_HI_RESET);
      sfr_put(`IWB_SFR_WIDE_HI, 8'ha5);
      sfr_put(8'hf8, 8'h11);
      sfr_get(`IWB_SFR_WIDE_HI, 8'ha5);
      sfr_get(8'hf8, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         double_speed = i[0];
         strobe_stretch = i[1];
         mpt = i[0] ? 1 : 2;
         tk = i[1] ? 18 : 6;
         sl = i[1] ? 15 : 3;
         // the previous wide read overwrote the high byte, so software reloads it
         sfr_put(`IWB_SFR_WIDE_HI, 8'ha5);
         mv(1'b1, 1'b0, 16'h1234 + 16'(i), 8'h3c + 8'(i));
         `CHK(wr_word, {8'ha5, 8'h3c + 8'(i)})
         `CHK(lat_addr, 8'h34 + 8'(i))
         `CHK(hi_seen, 8'h12)
         `CHK(cyc, tk * mpt + 1)
         `CHK(strobe_len, sl * mpt)
         rd_word = 16'hbe00 + 16'(i);
         mv(1'b0, 1'b0, 16'h2345, 8'h00);
         `CHK(cpu_result, 8'(i))
         `CHK(cyc, tk * mpt + 1)
         `CHK(strobe_len, sl * mpt)
         sfr_get(`IWB_SFR_WIDE_HI, 8'hbe);
      end
      rd_word = 16'h7e81;
      mv(1'b0, 1'b1, 16'h7788, 8'h00);
      `CHK(hi_seen, 8'h5a)
      `CHK(cpu_result, 8'h81)
      sfr_get(`IWB_SFR_WIDE_HI, 8'h7e);
      page_access_disable = 1'b1;
      sfr_put(`IWB_SFR_WIDE_HI, 8'h66);
      mv(1'b1, 1'b0, 16'h9911, 8'h22);
      `CHK(hi_seen, 8'h5a)
      `CHK(wr_word, 16'h6622)
      page_access_disable = 1'b0;
      wide_bus_enable = 1'b0;
      rd_word = 16'hc3d4;
      mv(1'b0, 1'b0, 16'h4455, 8'h00);
      `CHK(cpu_result, 8'hd4)
      `CHK(hi_seen, 8'h44)
      sfr_get(`IWB_SFR_WIDE_HI, 8'h66);
      give_verdict;
   end
endmodule // tb_iwb_port
